// file: hw/atl_pkg.sv
// shared constants, types and mode table of the transport lane mapper
package atl_pkg;

    localparam int SMP_W     = 9;    // converter core resolution
    localparam int WORD_W    = 12;   // widest transmitted word
    localparam int MAX_WORDS = 5;    // most words per lane per batch
    localparam int MAX_LANES = 4;    // serial lanes of the single-channel part
    localparam int LANE_BITS = 64;   // widest per-lane batch (eight octets)
    localparam int NUM_SMP   = MAX_WORDS * MAX_LANES;
    localparam int CH_SMP    = 10;   // samples per lane pair per frame, mode 0

    localparam logic [3:0]  MODE_PAIRED  = 4'h0;   // even/odd lane pairing mode
    localparam logic [3:0]  NP_BYTE      = 4'h8;   // 8-bit word width
    localparam logic [10:0] FCLK_MIN_MHZ = 11'h1f4;  // 500 MHz
    localparam logic [10:0] FCLK_LO_MHZ  = 11'h410;  // 1040 MHz
    localparam logic [10:0] FCLK_HI_MHZ  = 11'h514;  // 1300 MHz
    localparam logic [8:0]  K_MAX        = 9'h100;   // 256
    localparam logic [8:0]  K_STEP4      = 9'h004;
    localparam logic [8:0]  K_STEP32     = 9'h020;
    localparam logic [8:0]  K_128        = 9'h080;
    localparam logic [3:0]  ALIGN_CYC    = 4'h4;   // realignment hold after enable
    localparam int          R_FRAC_BITS  = 5;      // lane-rate ratio fraction bits

    typedef enum logic {
        ENC_8B10B  = 1'b0,
        ENC_64B66B = 1'b1
    } atl_enc_type;

    typedef struct packed {
        logic        ok;      // mode supported
        atl_enc_type enc;
        logic [3:0]  n;       // sample resolution
        logic [3:0]  np;      // transmitted word width
        logic [2:0]  l;       // lanes
        logic [2:0]  m;
        logic [3:0]  f;       // octets per frame
        logic [2:0]  s;
        logic [1:0]  hd;
        logic [1:0]  e;
        logic [8:0]  k_base;  // fixed K, or least K
        logic [8:0]  k_step;  // zero when K is fixed
        logic [9:0]  r_fx;    // lane-rate ratio, 5 fraction bits
        logic [10:0] fmax;    // highest sample clock in MHz
        logic [2:0]  words;   // words per lane per batch
        logic [3:0]  octets;  // octets per lane per batch
    } atl_cfg_type;

    // packs one table row into a configuration word
    function automatic atl_cfg_type atl_mk(
        input atl_enc_type enc, input logic [3:0] n, input logic [3:0] np,
        input logic [2:0] l, input logic [2:0] m, input logic [3:0] f,
        input logic [2:0] s, input logic [1:0] hd, input logic [1:0] e,
        input logic [8:0] kb, input logic [8:0] ks, input logic [9:0] r,
        input logic [10:0] fmax, input logic [2:0] words, input logic [3:0] oct);
        atl_cfg_type c;
        c = '{1'b1, enc, n, np, l, m, f, s, hd, e, kb, ks, r, fmax, words, oct};
        return c;
    endfunction

    // per-mode transport parameters
    function automatic atl_cfg_type atl_mode_cfg(input logic [3:0] mode);
        atl_cfg_type c;
        c = '0;
        case (mode)
            4'h0: c = atl_mk(ENC_8B10B, 4'h9, 4'hc, 3'h4, 3'h4, 4'h8, 3'h5, 2'h0, 2'h0,
                             K_STEP4, K_STEP4, 10'h100, FCLK_HI_MHZ, 3'h5, 4'h8);
            4'h2: c = atl_mk(ENC_8B10B, 4'h8, 4'h8, 3'h1, 3'h4, 4'h1, 3'h1, 2'h0, 2'h0,
                             K_STEP32, K_STEP32, 10'h140, FCLK_HI_MHZ, 3'h1, 4'h1);
            4'h3: c = atl_mk(ENC_8B10B, 4'h9, 4'ha, 3'h1, 3'h4, 4'h5, 3'h4, 2'h0, 2'h0,
                             K_STEP32, K_STEP32, 10'h190, FCLK_HI_MHZ, 3'h4, 4'h5);
            4'h4: c = atl_mk(ENC_64B66B, 4'h9, 4'hc, 3'h1, 3'h4, 4'h2, 3'h1, 2'h1, 2'h3,
                             K_128, 9'h000, 10'h210, FCLK_LO_MHZ, 3'h4, 4'h6);
            4'h5: c = atl_mk(ENC_64B66B, 4'h8, 4'h8, 3'h1, 3'h4, 4'h2, 3'h1, 2'h0, 2'h1,
                             K_128, 9'h000, 10'h210, FCLK_LO_MHZ, 3'h2, 4'h2);
            4'h6: c = atl_mk(ENC_64B66B, 4'h9, 4'hc, 3'h2, 3'h4, 4'h2, 3'h2, 2'h1, 2'h3,
                             K_128, 9'h000, 10'h108, FCLK_HI_MHZ, 3'h4, 4'h6);
            4'h7: c = atl_mk(ENC_64B66B, 4'h8, 4'h8, 3'h1, 3'h4, 4'h1, 3'h1, 2'h0, 2'h1,
                             K_MAX, 9'h000, 10'h108, FCLK_HI_MHZ, 3'h1, 4'h1);
            4'h8: c = atl_mk(ENC_64B66B, 4'h9, 4'hc, 3'h1, 3'h4, 4'h3, 3'h2, 2'h0, 2'h3,
                             K_MAX, 9'h000, 10'h18c, FCLK_HI_MHZ, 3'h2, 4'h3);
            4'h9: c = atl_mk(ENC_8B10B, 4'h8, 4'h8, 3'h2, 3'h4, 4'h1, 3'h2, 2'h0, 2'h0,
                             K_STEP32, K_STEP32, 10'h0a0, FCLK_HI_MHZ, 3'h1, 4'h1);
            4'ha: c = atl_mk(ENC_8B10B, 4'h9, 4'ha, 3'h2, 3'h2, 4'h5, 3'h4, 2'h0, 2'h0,
                             K_STEP32, K_STEP32, 10'h0c8, FCLK_HI_MHZ, 3'h4, 4'h5);
            4'hb: c = atl_mk(ENC_8B10B, 4'h9, 4'hc, 3'h4, 3'h4, 4'h8, 3'h5, 2'h0, 2'h0,
                             K_STEP4, K_STEP4, 10'h080, FCLK_HI_MHZ, 3'h5, 4'h8);
            4'hc: c = atl_mk(ENC_8B10B, 4'h8, 4'h8, 3'h4, 3'h1, 4'h1, 3'h4, 2'h0, 2'h0,
                             K_STEP32, K_STEP32, 10'h050, FCLK_HI_MHZ, 3'h1, 4'h1);
            4'hd: c = atl_mk(ENC_8B10B, 4'h9, 4'ha, 3'h4, 3'h4, 4'h5, 3'h4, 2'h0, 2'h0,
                             K_STEP32, K_STEP32, 10'h064, FCLK_HI_MHZ, 3'h4, 4'h5);
            4'he: c = atl_mk(ENC_64B66B, 4'h9, 4'hc, 3'h2, 3'h2, 4'h3, 3'h2, 2'h0, 2'h3,
                             K_MAX, 9'h000, 10'h0c6, FCLK_HI_MHZ, 3'h2, 4'h3);
            4'hf: c = atl_mk(ENC_64B66B, 4'h9, 4'hc, 3'h4, 3'h4, 4'h3, 3'h2, 2'h2, 2'h2,
                             K_MAX, 9'h000, 10'h063, FCLK_HI_MHZ, 3'h2, 4'h3);
            default: c = '0;   // mode 1 has no single-channel form
        endcase
        return c;
    endfunction

    // stream index of the sample carried by word w of lane l
    function automatic int atl_smp_index(input logic paired, input int l, input int w,
                                         input int lanes);
        if (paired)
            return (l / 2) * CH_SMP + w * 2 + (l % 2);
        return w * lanes + l;
    endfunction

endpackage

// file: hw/atl_cfg_if.sv
// mode configuration carried from the decoder to the lane packers
`timescale 1ns/10ps
interface atl_cfg_if;
    import atl_pkg::*;
    atl_cfg_type cfg;
    modport src (output cfg);
    modport snk (input cfg);
endinterface

// file: hw/atl_mode_decoder.sv
// decodes the selected link format into its transport parameters
`timescale 1ns/10ps
module atl_mode_decoder
    import atl_pkg::*;
(
    input  wire logic [3:0] mode_i,   // registered link format
    atl_cfg_if.src          cfg_o     // decoded parameters
);
    // table lookup
    always_comb begin
        cfg_o.cfg = atl_mode_cfg(mode_i);
    end
endmodule // atl_mode_decoder

// file: hw/atl_lane_packer.sv
// packs one lane's words MSB first into a left-aligned batch
`timescale 1ns/10ps
module atl_lane_packer
    import atl_pkg::*;
(
    atl_cfg_if.snk                          cfg_i,    // active parameters
    input  wire logic [MAX_WORDS*SMP_W-1:0] words_i,  // word 0 in the low slot
    output logic      [LANE_BITS-1:0]       lane_o    // batch, first bit at msb
);
    // each sample left-aligned in a 12-bit slot, low bits zero; tail stays zero
    always_comb begin
        logic [WORD_W-1:0]    wd;
        logic [LANE_BITS-1:0] acc;
        int                   pos;
        wd  = '0;
        acc = '0;
        pos = 0;
        for (int w = 0; w < MAX_WORDS; w++) begin
            if (w < int'(cfg_i.cfg.words)) begin
                if (cfg_i.cfg.np == NP_BYTE)
                    wd = {words_i[w*SMP_W+1 +: SMP_W-1], 4'h0};   // 8-bit resolution
                else
                    wd = {words_i[w*SMP_W +: SMP_W], 3'h0};       // zero fill
                acc = acc | ({wd, {(LANE_BITS-WORD_W){1'b0}}} >> pos); // msb first
                pos = pos + int'(cfg_i.cfg.np);
            end
        end
        lane_o = acc;   // bits past the last word are tail zeros
    end
endmodule // atl_lane_packer

// file: hw/atl_lane_mapper.sv
// transport-layer lane mapper of the single-channel converter link
// Function
// - modes 2, 9: 8-bit, F=1, K 32:32:256
// - mode 3: 9-bit in 10, one lane
// - modes 4, 8: 9-bit in 12, 64B/66B
// - mode 5: 8-bit, 64B/66B, 500-1040 MHz only
// - modes 6, 14: two 64B/66B lanes, 12-bit
// - mode 7: 8-bit, one 64B/66B lane
// - mode 10: 9-bit in 10, two lanes
// - modes 11, 13: four 8B/10B lanes
// - mode 12: 8-bit over four lanes
// - mode 15: four 64B/66B lanes, HD=2
// - 64B/66B K fixed, not user set
// - single-channel part has four lanes
// - use low lanes, power down the rest
// - tail bits are always zero
// - samples go out MSB first
// - surplus word LSBs are zero
// - mode 0: five 12-bit words, 4-bit tail
`timescale 1ns/10ps
module atl_lane_mapper
    import atl_pkg::*;
#(
    parameter int LANES = MAX_LANES   // serial lanes of this part
)
(
    input  wire logic                       clk_i,                 // sample clock
    input  wire logic                       rst_i,                 // sync reset, high
    input  wire logic                       link_enable_i,         // serial link enabled
    input  wire logic [3:0]                 link_format_select_i,  // link mode
    input  wire logic [8:0]                 k_user_i,              // requested K, 8B/10B
    input  wire logic [10:0]                fclk_mhz_i,            // sample clock rate
    input  wire logic                       sample_valid_i,        // batch offered
    output logic                            sample_ready_o,        // batch taken
    input  wire logic [NUM_SMP*SMP_W-1:0]   sample_i,              // batch, oldest low
    output logic [LANES*LANE_BITS-1:0]      lane_data_o,           // per-lane batches
    output logic                            lane_valid_o,          // batches valid
    input  wire logic                       lane_ready_i,          // link layer takes
    output logic [3:0]                      lane_octets_o,         // octets per lane
    output logic [LANES-1:0]                lane_pd_o,             // lane powered down
    output logic                            link_ready_o,          // aligned, running
    output logic [8:0]                      k_o,                   // active K
    output atl_cfg_type                     cfg_o,                 // active parameters
    output logic                            mode_error_o,          // unsupported mode
    output logic                            rate_error_o,          // clock out of range
    output logic                            k_error_o              // bad K, max used
);

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ALIGN = 2'b01,
        ST_RUN   = 2'b10
    } atl_state_type;

    typedef struct packed {
        atl_state_type                st;
        logic [3:0]                   mode;
        logic [3:0]                   cnt;
        atl_cfg_type                  cfg;
        logic [LANES*LANE_BITS-1:0]   data;
        logic                         vld;
        logic [LANES-1:0]             pd;
        logic [8:0]                   k;
        logic                         kerr;
        logic                         rerr;
    } atl_regs_type;

    atl_regs_type q_ff;
    atl_regs_type nxt_q;

    atl_cfg_if dec_if ();
    atl_cfg_if act_if ();

    logic [LANES*LANE_BITS-1:0]     packed_lanes;
    logic [MAX_WORDS*SMP_W-1:0]     lane_words [LANES];
    logic                           rate_ok;
    logic                           take;

    // K legality: fixed for 64B/66B, else min..max on the step grid
    function automatic logic [9:0] atl_pick_k(input atl_cfg_type c, input logic [8:0] ku);
        if (c.enc == ENC_64B66B)
            return {1'b0, c.k_base};   // user K ignored
        if (ku >= c.k_base && ku <= K_MAX && (ku & (c.k_step - 9'h001)) == 9'h000)
            return {1'b0, ku};
        return {1'b1, K_MAX};
    endfunction

    // decoded parameters of the latched mode
    atl_mode_decoder u_dec (
        .mode_i (q_ff.mode),
        .cfg_o  (dec_if.src)
    );

    // packers see the registered copy
    always_comb begin
        act_if.cfg = q_ff.cfg;
    end

    // route stream samples to lane words in time order
    always_comb begin
        int idx;
        idx = 0;
        for (int l = 0; l < LANES; l++) begin
            lane_words[l] = '0;
            for (int w = 0; w < MAX_WORDS; w++) begin
                idx = atl_smp_index(q_ff.mode == MODE_PAIRED, l, w, int'(q_ff.cfg.l));
                if (idx < NUM_SMP)
                    lane_words[l][w*SMP_W +: SMP_W] = sample_i[idx*SMP_W +: SMP_W];
            end
        end
    end

    // one packer per lane
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        atl_lane_packer u_pack (
            .cfg_i   (act_if.snk),
            .words_i (lane_words[g]),
            .lane_o  (packed_lanes[g*LANE_BITS +: LANE_BITS])
        );
    end

    // clock must sit in the mode's range
    assign rate_ok = fclk_mhz_i >= FCLK_MIN_MHZ && fclk_mhz_i <= q_ff.cfg.fmax;

    // input handshake: only while running and the output stage can move
    assign sample_ready_o = (q_ff.st == ST_RUN) && (!q_ff.vld || lane_ready_i);
    assign take           = sample_ready_o && sample_valid_i;

    // next-state logic
    always_comb begin
        logic [9:0] kp;
        nxt_q      = q_ff;
        kp         = atl_pick_k(q_ff.cfg, k_user_i);
        nxt_q.cfg  = dec_if.cfg;
        nxt_q.k    = kp[8:0];
        nxt_q.kerr = kp[9];
        nxt_q.rerr = q_ff.cfg.ok && !rate_ok;
        // lowest lanes carry data, higher ones are shut off
        for (int i = 0; i < LANES; i++) begin
            nxt_q.pd[i] = !q_ff.cfg.ok || (i >= int'(q_ff.cfg.l));
        end
        if (lane_ready_i)
            nxt_q.vld = 1'b0;
        if (take) begin
            nxt_q.data = packed_lanes;
            nxt_q.vld  = 1'b1;
        end
        case (q_ff.st)
            ST_IDLE: begin
                nxt_q.cnt = '0;
                if (link_enable_i && q_ff.cfg.ok && rate_ok)
                    nxt_q.st = ST_ALIGN;
            end
            ST_ALIGN: begin
                nxt_q.cnt = q_ff.cnt + 4'h1;
                if (q_ff.cnt == ALIGN_CYC - 4'h1)
                    nxt_q.st = ST_RUN;       // data valid only after realignment
            end
            ST_RUN: begin
                if (!rate_ok)
                    nxt_q.st = ST_IDLE;
            end
            default: nxt_q.st = ST_IDLE;
        endcase
        // format only follows the select while the link is off
        if (!link_enable_i) begin
            nxt_q.st   = ST_IDLE;
            nxt_q.mode = link_format_select_i;
            nxt_q.vld  = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_ff      <= '0;
            q_ff.mode <= MODE_PAIRED;
            q_ff.pd   <= '1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // outputs straight from the state register
    assign lane_data_o   = q_ff.data;
    assign lane_valid_o  = q_ff.vld;
    assign lane_octets_o = q_ff.cfg.octets;
    assign lane_pd_o     = q_ff.pd;
    assign link_ready_o  = q_ff.st == ST_RUN;
    assign k_o           = q_ff.k;
    assign cfg_o         = q_ff.cfg;
    assign mode_error_o  = !q_ff.cfg.ok;
    assign rate_error_o  = q_ff.rerr;
    assign k_error_o     = q_ff.kerr;

endmodule // atl_lane_mapper

// file: tb/atl_mapper_assertions.sv
// concurrent checks on the lane mapper ports, bound to the design
`timescale 1ns/10ps
module atl_mapper_checker
    import atl_pkg::*;
#(
    parameter int LANES = MAX_LANES  // serial lanes
)
(
    input wire logic                         clk_i,           // sample clock
    input wire logic                         rst_i,           // sync reset
    input wire logic                         link_enable_i,   // link enable
    input wire logic [10:0]                  fclk_mhz_i,      // clock rate
    input wire logic                         sample_valid_i,  // batch offered
    input wire logic                         sample_ready_o,  // batch taken
    input wire logic [LANES*LANE_BITS-1:0]   lane_data_o,     // lane batches
    input wire logic                         lane_valid_o,    // batches held
    input wire logic                         lane_ready_i,    // link takes
    input wire logic [3:0]                   lane_octets_o,   // octets per lane
    input wire logic [LANES-1:0]             lane_pd_o,       // lanes down
    input wire logic                         link_ready_o,    // running
    input wire logic [8:0]                   k_o,             // active K
    input wire atl_cfg_type                  cfg_o            // active mode
);
    // highest clock rate of the active mode: one-lane F=2 modes stop at 1040
    wire logic [10:0] lim = (cfg_o.f == 4'h2 && cfg_o.l == 3'h1) ? FCLK_LO_MHZ : FCLK_HI_MHZ;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // lane stream checks
    take_to_lane_a: assert property (sample_valid_i && sample_ready_o |=> lane_valid_o)
        else $error("taken batch not presented");
    hold_batch_a: assert property (lane_valid_o && !lane_ready_i |=> $stable(lane_data_o))
        else $error("stalled batch changed");
    data_load_a: assert property (!(sample_valid_i && sample_ready_o) |=>
        $stable(lane_data_o)) else $error("batch changed without a take");
    batch_release_a: assert property (lane_valid_o && lane_ready_i && !sample_valid_i |=>
        !lane_valid_o) else $error("accepted batch still presented");
    tail_zero_a: assert property (lane_valid_o |->
        (lane_data_o[63:0] << {lane_octets_o, 3'h0}) == 64'h0) else $error("tail bits not zero");
    surplus_zero_a: assert property (lane_valid_o && cfg_o.np == 4'hc |->
        lane_data_o[54:52] == 3'h0) else $error("surplus word bits not zero");
    // link setup checks
    pd_low_lanes_a: assert property (link_ready_o |-> lane_pd_o == LANES'(4'hf << cfg_o.l))
        else $error("wrong lanes powered down");
    k_fixed_a: assert property (link_ready_o && cfg_o.enc == ENC_64B66B |->
        k_o == ((cfg_o.f == 4'h2) ? 9'h080 : 9'h100)) else $error("fixed K wrong");
    align_hold_a: assert property ($rose(link_enable_i) |-> !link_ready_o [*5])
        else $error("link ready before realignment");
    enable_drop_a: assert property (!link_enable_i |=> !link_ready_o)
        else $error("link ready while disabled");
    rate_limit_a: assert property ((link_enable_i && fclk_mhz_i > lim) [*3] |-> !link_ready_o)
        else $error("link runs above clock limit");
    ready_gate_a: assert property (sample_ready_o |->
        link_ready_o && (!lane_valid_o || lane_ready_i)) else $error("samples taken too early");

    // main scenarios
    cover property (link_ready_o && lane_valid_o && !lane_ready_i);
    cover property ($rose(link_ready_o));
    cover property (link_enable_i && fclk_mhz_i > lim);
endmodule // atl_mapper_checker

bind atl_lane_mapper atl_mapper_checker #(.LANES(LANES)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .link_enable_i(link_enable_i), .fclk_mhz_i(fclk_mhz_i),
    .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
    .lane_data_o(lane_data_o), .lane_valid_o(lane_valid_o), .lane_ready_i(lane_ready_i),
    .lane_octets_o(lane_octets_o), .lane_pd_o(lane_pd_o), .link_ready_o(link_ready_o),
    .k_o(k_o), .cfg_o(cfg_o));

// file: tb/atl_rx_model.sv
// link receiver stand-in that takes lane batches promptly or slowly
`timescale 1ns/10ps
module atl_rx_model (
    input  wire logic clk_i,         // sample clock
    input  wire logic rst_i,         // sync reset, high
    input  wire logic slow_i,        // stall most cycles
    output logic      lane_ready_o   // batch accepted
);
    logic [1:0] cnt_ff;
    // ready every cycle, or one cycle in four when slow
    always @(posedge clk_i) begin
        cnt_ff <= #1 rst_i ? 2'h0 : cnt_ff + 2'h1;
        lane_ready_o <= #1 !rst_i && (!slow_i || cnt_ff == 2'h3);
    end
endmodule // atl_rx_model

// file: tb/test_adc_transport_lane_mapper.sv
// self-checking bench of the transport lane mapper
`timescale 1ns/10ps
module test_adc_transport_lane_mapper
    import atl_pkg::*;
;
    // lanes, word width and words per lane batch for each link mode
    localparam int LL [16] = '{4, 0, 1, 1, 1, 1, 2, 1, 1, 2, 2, 4, 4, 4, 2, 4};
    localparam int NP [16] = '{12, 0, 8, 10, 12, 8, 12, 8, 12, 8, 10, 12, 8, 10, 12, 12};
    localparam int WD [16] = '{5, 0, 1, 4, 4, 2, 4, 1, 2, 1, 4, 5, 1, 4, 2, 2};
    // frame octets, samples per frame, converters, E and lane-rate ratio times 32 per mode
    localparam int FF [16] = '{8, 0, 1, 5, 2, 2, 2, 1, 3, 1, 5, 8, 1, 5, 3, 3};
    localparam int SS [16] = '{5, 0, 1, 4, 1, 1, 2, 1, 2, 2, 4, 5, 4, 4, 2, 2};
    localparam int MM [16] = '{4, 0, 4, 4, 4, 4, 4, 4, 4, 4, 2, 4, 1, 4, 2, 4};
    localparam int EE [16] = '{0, 0, 0, 0, 3, 1, 3, 1, 3, 0, 0, 0, 0, 0, 3, 2};
    localparam int RR [16] = '{256, 0, 320, 400, 528, 528, 264, 264, 396, 160, 200, 128, 80, 100,
                               198, 99};
    logic         clk_i, rst_i, link_enable_i, sample_valid_i, lane_ready_i, slow;
    logic         sample_ready_o, lane_valid_o, link_ready_o;
    logic         mode_error_o, rate_error_o, k_error_o;
    logic [3:0]   mode, lane_pd_o, lane_octets_o;
    atl_cfg_type  cfg_o;
    logic [8:0]   k_user, k_o;
    logic [10:0]  fclk;
    logic [179:0] smp;
    logic [255:0] lane_data_o;
    logic [255:0] expq[$], mskq[$];
    logic [31:0]  seed = 32'h13;
    int           n_mismatch = 0, checks = 0, n;

    atl_lane_mapper dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .link_enable_i(link_enable_i),
        .link_format_select_i(mode), .k_user_i(k_user), .fclk_mhz_i(fclk),
        .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .sample_i(smp),
        .lane_data_o(lane_data_o), .lane_valid_o(lane_valid_o), .lane_ready_i(lane_ready_i),
        .lane_octets_o(lane_octets_o), .lane_pd_o(lane_pd_o), .link_ready_o(link_ready_o),
        .k_o(k_o), .cfg_o(cfg_o), .mode_error_o(mode_error_o), .rate_error_o(rate_error_o),
        .k_error_o(k_error_o));
    atl_rx_model rx_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .lane_ready_o(lane_ready_i));

    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [255:0] seen, input logic [255:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // lane batches worked out from the sample order of each mode
    function automatic logic [255:0] exp_lanes(input int m, input logic [179:0] s);
        logic [255:0] e;
        logic [11:0]  wv;
        int           ix;
        e = '0;
        for (int l = 0; l < LL[m]; l++)
            for (int w = 0; w < WD[m]; w++) begin
                ix = (m == 0) ? (l / 2) * 10 + 2 * w + l % 2 : w * LL[m] + l;
                wv = {s[ix*9+:9], 3'h0};
                for (int b = 0; b < NP[m]; b++)
                    e[l*64+63-w*NP[m]-b] = wv[11-b];
            end
        return e;
    endfunction

    // select a mode with the link off, then enable and count edges to ready
    task automatic setup(input int m, input logic [8:0] k, input logic [10:0] f, output int c);
        link_enable_i = 1'b0;
        mode = 4'(m);
        k_user = k;
        fclk = f;
        repeat (3) @(posedge clk_i);
        #1 link_enable_i = 1'b1;
        c = 0;
        while (!link_ready_o && c < 12) begin
            @(posedge clk_i);
            #1 c++;
        end
    endtask

    task automatic run_mode(input int m);
        logic [31:0]  r;
        logic [255:0] msk;
        int           t;
        logic [46:0]  ce, cs;
        r = xs();
        setup(m, {1'b0, r[2:0], 5'h0} + 9'h020, 11'h410, t);
        chk("ready_edges", t, 5);
        chk("k", k_o, m inside {4, 5, 6} ? 9'h080 : m inside {7, 8, 14, 15} ? 9'h100 : k_user);
        chk("pd", lane_pd_o, 4'(4'hf << LL[m]));
        chk("octets", lane_octets_o, (WD[m] * NP[m] + 7) / 8);
        chk("errs", {mode_error_o, rate_error_o, k_error_o}, 3'h0);
        // active parameters against the mode table
        cs = {cfg_o.enc, cfg_o.n, cfg_o.np, cfg_o.l, cfg_o.m, cfg_o.f, cfg_o.s, cfg_o.hd, cfg_o.e,
              cfg_o.r_fx, cfg_o.fmax};
        ce = {EE[m] != 0, 4'(NP[m] == 8 ? 8 : 9), 4'(NP[m]), 3'(LL[m]), 3'(MM[m]), 4'(FF[m]),
              3'(SS[m]), 2'(m == 15 ? 2 : (m == 4 || m == 6) ? 1 : 0), 2'(EE[m]), 10'(RR[m]),
              ((m inside {4, 5}) ? FCLK_LO_MHZ : FCLK_HI_MHZ)};
        chk("cfg", cs, ce);
        msk = (LL[m] == 4) ? '1 : (256'h1 << (LL[m] * 64)) - 256'h1;
        slow = r[3];
        repeat (3) begin
            for (int j = 0; j < 20; j++) begin
                r = xs();
                smp[j*9+:9] = r[8:0];
            end
            sample_valid_i = 1'b1;
            t = 0;
            do begin
                @(posedge clk_i);
                t++;
            end while (!sample_ready_o && t < 50);
            chk("take", t < 50, 1'b1);
            expq.push_back(exp_lanes(m, smp) & msk);
            mskq.push_back(msk);
            #1;
        end
        sample_valid_i = 1'b0;
        t = 0;
        while (expq.size() > 0 && t < 200) begin
            @(posedge clk_i);
            #1 t++;
        end
        chk("drained", expq.size(), 0);
    endtask

    // compare each batch handed to the receiver with the oldest note
    always @(posedge clk_i) begin
        if (!rst_i && lane_valid_o && lane_ready_i) begin
            if (expq.size() == 0)
                chk("extra_batch", 1'b1, 1'b0);
            else
                chk("lane_data", lane_data_o & mskq.pop_front(), expq.pop_front());
        end
    end

    // main sequence: every supported mode, then refusals
    initial begin
        rst_i = 1'b1;
        link_enable_i = 1'b0;
        sample_valid_i = 1'b0;
        slow = 1'b0;
        mode = 4'h0;
        k_user = 9'h020;
        fclk = 11'h410;
        smp = '0;
        repeat (6) @(posedge clk_i);
        #1 chk("pd_reset", lane_pd_o, 4'hf);
        rst_i = 1'b0;
        for (int m = 0; m < 16; m++)
            if (m != 1)
                run_mode(m);
        setup(5, 9'h020, 11'h44c, n);
        chk("rate_err", {link_ready_o, rate_error_o}, 2'b01);
        setup(1, 9'h020, 11'h3e8, n);
        chk("mode_err", {link_ready_o, mode_error_o}, 2'b01);
        setup(2, 9'h021, 11'h3e8, n);
        chk("k_err", {k_error_o, k_o}, {1'b1, K_MAX});
        end_of_test();
    end

    // watchdog: the whole run needs well under 2000 cycles
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
endmodule // test_adc_transport_lane_mapper
